// ==== rtl/cspi_defines.svh ====
/*
  Constants of the sync and process image counter slice: image byte
  offsets, bit positions inside the status and command bytes, reset
  values and timing figures.
  Assumes inclusion by bare name from the design files.
*/
`ifndef CSPI_DEFINES_SVH
`define CSPI_DEFINES_SVH

// Image byte offsets
`define CSPI_OFS_COUNT      4'h0
`define CSPI_OFS_FAULT      4'h4
`define CSPI_OFS_DIRGATE    4'h5
`define CSPI_OFS_LIMSYNC    4'h6
`define CSPI_OFS_SPARE      4'h7
`define CSPI_OFS_COUNT_EXT  4'h8

// Feedback byte 4
`define CSPI_FB4_SUPPLY     7
`define CSPI_FB4_PARAM      5
`define CSPI_FB4_CLR_ACK    2
`define CSPI_FB4_LOAD_FLT   1
`define CSPI_FB4_LOAD_ACT   0
// Feedback byte 5
`define CSPI_FB5_DOWN       7
`define CSPI_FB5_UP         6
`define CSPI_FB5_LEVEL      1
`define CSPI_FB5_GATE       0
// Feedback byte 6
`define CSPI_FB6_ZERO       7
`define CSPI_FB6_LOW        6
`define CSPI_FB6_HIGH       5
`define CSPI_FB6_SYNC       0

// Control byte 4
`define CSPI_CB4_FAULT_ACK  7
`define CSPI_CB4_CLR_REQ    2
`define CSPI_CB4_ARM        1
`define CSPI_CB4_GATE       0
// Control byte 5 load and compare commands
`define CSPI_CB5_DIRECT     0
`define CSPI_CB5_PREP       1
`define CSPI_CB5_CMP1       2
`define CSPI_CB5_CMP2       3

// Reset values
`define CSPI_RST_LOAD       32'h0000_0000
`define CSPI_RST_COUNT      32'h0000_0000
`define CSPI_RST_LATCH      32'h0000_0000

// Timing
`define CSPI_CLK_PERIOD_NS  8
`define CSPI_PULSE_UNIT_NS  2000000
`define CSPI_PULSE_UNIT_CYC (`CSPI_PULSE_UNIT_NS / `CSPI_CLK_PERIOD_NS)

`endif

// ==== rtl/cspi_pkg.sv ====
/*
  Types of the sync and process image counter slice: images, modes,
  sync state and the module state record.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cspi_pkg;

  typedef enum logic [1:0] {
    CSPI_AUX_INPUT  = 2'h0,
    CSPI_AUX_HWGATE = 2'h1,
    CSPI_AUX_LATCH  = 2'h2,
    CSPI_AUX_SYNC   = 2'h3
  } cspi_auxfn_t;

  typedef enum logic [1:0] {
    CSPI_SY_IDLE  = 2'h0,
    CSPI_SY_ARMED = 2'h1,
    CSPI_SY_DONE  = 2'h3
  } cspi_sync_t;

  typedef struct packed {
    logic [31:0] value;
    logic [7:0]  cmd;
    logic [7:0]  load;
  } cspi_ctrl_img_t;

  typedef struct packed {
    logic [31:0] count;
    logic [7:0]  fault;
    logic [7:0]  dirgate;
    logic [7:0]  limsync;
    logic [7:0]  spare;
    logic [31:0] count_ext;
  } cspi_fb_img_t;

  typedef struct packed {
    cspi_ctrl_img_t     ctrl;
    cspi_sync_t         sync;
    logic               aux_s1;
    logic               aux_s2;
    logic               aux_s3;
    logic               gate_open;
    logic signed [31:0] count;
    logic [31:0]        load_val;
    logic [31:0]        latch_val;
    logic [31:0]        cmp1;
    logic [31:0]        cmp2;
    logic               sync_seen_flag;
    logic               zero_cross_flag;
    logic               low_limit_flag;
    logic               high_limit_flag;
    logic               dir_up_flag;
    logic               dir_down_flag;
    logic               encoder_supply_fault;
    logic               param_fault;
    logic               load_fault;
    logic               load_active;
    logic               status_clear_ack;
    logic [27:0]        tick_cnt;
    logic [7:0]         ptmr1;
    logic [7:0]         ptmr2;
    logic               out1;
    logic               out2;
    cspi_fb_img_t       fb;
  } cspi_state_t;

endpackage : cspi_pkg

// ==== rtl/cspi_top.sv ====
/*
  Counter slice with reference-edge synchronization and the cyclic
  control and feedback images exchanged with the fieldbus interface.
  Assumes the interface module presents a whole control image with a
  one-cycle valid strobe, and gives a sample strobe per bus cycle in
  isochronous mode; all inputs are synchronous to clk_in except the
  reset and the auxiliary input, which are synchronized here.
*/
`include "cspi_defines.svh"

module cspi_top
  import cspi_pkg::*;
#(
  parameter int PULSE_UNIT_CYC = `CSPI_PULSE_UNIT_CYC
) (
  input  wire logic           clk_in,
  input  wire logic           rstn_in,
  input  wire logic           ce_in,
  input  wire cspi_auxfn_t    aux_func_in,
  input  wire logic           sync_periodic_in,
  input  wire logic           iso_mode_in,
  input  wire logic           sample_in,
  input  wire cspi_ctrl_img_t ctrl_img_in,
  input  wire logic           ctrl_valid_in,
  input  wire logic           aux_input_in,
  input  wire logic           count_pulse_in,
  input  wire logic           count_up_in,
  input  wire logic           supply_short_in,
  output cspi_fb_img_t        fb_img_out,
  output logic                output_one_out,
  output logic                output_two_out
);

  logic [1:0]  rsync_q;
  logic        rst_n;
  cspi_state_t state_q;
  cspi_state_t state_d;

  // Level compare with hysteresis, shared by both outputs
  function automatic logic cspi_level(
    input logic [1:0]         mode,
    input logic signed [31:0] cnt,
    input logic signed [31:0] cmp,
    input logic [7:0]         hy,
    input logic               cur
  );
    logic signed [32:0] c;
    logic signed [32:0] m;
    logic signed [32:0] lo;
    logic signed [32:0] hi;
    c  = {cnt[31], cnt};
    m  = {cmp[31], cmp};
    lo = m - $signed({25'h0, hy});
    hi = m + $signed({25'h0, hy});
    case (mode)
      2'h1:    cspi_level = cur ? (c >= lo) : (c >= m);
      2'h2:    cspi_level = cur ? (c <= hi) : (c <= m);
      default: cspi_level = 1'b0;
    endcase
  endfunction : cspi_level

  // More than one bit set
  function automatic logic cspi_multi(input logic [3:0] c);
    cspi_multi = (c & (c - 4'h1)) != 4'h0;
  endfunction : cspi_multi

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rsync_q <= 2'h0;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end
  assign rst_n = rsync_q[1];

  always_comb begin
    cspi_ctrl_img_t     nc;
    logic [3:0]         cmds;
    logic               gate_rise;
    logic               clr_rise;
    logic               gate_int;
    logic               aux_edge;
    logic               sync_hit;
    logic               ack;
    logic               tick;
    logic signed [31:0] cnt;
    logic [2:0]         do1;
    logic [1:0]         do2;
    logic               reach1;
    logic               reach2;
    logic               load_ok;
    state_d = state_q;
    nc        = state_q.ctrl;
    gate_rise = 1'b0;
    clr_rise  = 1'b0;
    load_ok   = 1'b0;
    sync_hit  = 1'b0;
    // Every local starts defined
    gate_int  = 1'b0;
    aux_edge  = 1'b0;
    ack       = 1'b0;
    tick      = 1'b0;
    cnt       = state_q.count;
    do1       = 3'h0;
    do2       = 2'h0;
    reach1    = 1'b0;
    reach2    = 1'b0;
    cmds = {state_q.ctrl.load[`CSPI_CB5_CMP2],
            state_q.ctrl.load[`CSPI_CB5_CMP1],
            state_q.ctrl.load[`CSPI_CB5_PREP],
            state_q.ctrl.load[`CSPI_CB5_DIRECT]};

    // Whole control image taken in one cycle
    if (ctrl_valid_in) begin
      nc = ctrl_img_in;
      gate_rise = nc.cmd[`CSPI_CB4_GATE] &
                  ~state_q.ctrl.cmd[`CSPI_CB4_GATE];
      clr_rise  = nc.cmd[`CSPI_CB4_CLR_REQ] &
                  ~state_q.ctrl.cmd[`CSPI_CB4_CLR_REQ];
      cmds = {nc.load[`CSPI_CB5_CMP2], nc.load[`CSPI_CB5_CMP1],
              nc.load[`CSPI_CB5_PREP], nc.load[`CSPI_CB5_DIRECT]};
    end
    state_d.ctrl = nc;
    ack = nc.cmd[`CSPI_CB4_FAULT_ACK];

    // Soft gate
    if (gate_rise) begin
      state_d.gate_open = 1'b1;
    end else if (!nc.cmd[`CSPI_CB4_GATE]) begin
      state_d.gate_open = 1'b0;
    end

    // Aux input synchronizer and edge
    state_d.aux_s1 = aux_input_in;
    state_d.aux_s2 = state_q.aux_s1;
    state_d.aux_s3 = state_q.aux_s2;
    aux_edge = state_q.aux_s2 & ~state_q.aux_s3;

    gate_int = state_q.gate_open &
               ((aux_func_in != CSPI_AUX_HWGATE) | state_q.aux_s2);

    // Sync state machine
    case (state_q.sync)
      CSPI_SY_IDLE: begin
        if (nc.cmd[`CSPI_CB4_ARM]) begin
          state_d.sync = CSPI_SY_ARMED;
        end
      end
      CSPI_SY_ARMED: begin
        if (!nc.cmd[`CSPI_CB4_ARM]) begin
          state_d.sync = CSPI_SY_IDLE;
        end else if (aux_edge && state_q.gate_open &&
                     aux_func_in == CSPI_AUX_SYNC) begin
          sync_hit = 1'b1;
          if (!sync_periodic_in) begin
            state_d.sync = CSPI_SY_DONE;
          end // else stays armed
        end
      end
      CSPI_SY_DONE: begin
        if (!nc.cmd[`CSPI_CB4_ARM]) begin
          state_d.sync = CSPI_SY_IDLE;
        end
      end
      default: state_d.sync = CSPI_SY_IDLE;
    endcase

    // Load and compare commands, one per transfer
    if (ctrl_valid_in && cmds != 4'h0) begin
      if (cspi_multi(cmds)) begin
        state_d.load_fault = 1'b1;
      end else begin
        load_ok = 1'b1;
        if (cmds[1]) begin
          state_d.load_val = nc.value;
        end
        if (cmds[2]) begin
          state_d.cmp1 = nc.value;
        end
        if (cmds[3]) begin
          state_d.cmp2 = nc.value;
        end
      end
    end else if (ack && !(ctrl_valid_in && cspi_multi(cmds))) begin
      state_d.load_fault = 1'b0;
    end
    state_d.load_active = load_ok | (state_q.load_active &&
                                     cmds != 4'h0);

    // Counter
    cnt = state_q.count;
    if (sync_hit) begin
      cnt = $signed(state_q.load_val);
    end else if (load_ok && cmds[0]) begin
      cnt = $signed(nc.value);
    end else if (gate_int && count_pulse_in) begin
      state_d.dir_up_flag   = count_up_in;
      state_d.dir_down_flag = ~count_up_in;
      cnt = count_up_in ? (state_q.count + 32'sd1) :
                          (state_q.count - 32'sd1);
      if (count_up_in && state_q.count == 32'sh7fff_ffff) begin
        state_d.high_limit_flag = 1'b1;
      end
      if (!count_up_in && state_q.count == 32'sh8000_0000) begin
        state_d.low_limit_flag = 1'b1;
      end
      if ((count_up_in && state_q.count == -32'sd1) ||
          (!count_up_in && state_q.count == 32'sd0)) begin
        state_d.zero_cross_flag = 1'b1;
      end
    end
    state_d.count = cnt;

    if (aux_func_in == CSPI_AUX_LATCH && aux_edge) begin
      state_d.latch_val = state_q.count;
    end

    // Sticky status: clear on request edge, new events win
    if (clr_rise) begin
      state_d.sync_seen_flag  = 1'b0;
      state_d.zero_cross_flag = 1'b0;
      state_d.low_limit_flag  = 1'b0;
      state_d.high_limit_flag = 1'b0;
      if (gate_int && count_pulse_in && !sync_hit &&
          !(load_ok && cmds[0])) begin
        state_d.zero_cross_flag = (count_up_in &&
          state_q.count == -32'sd1) || (!count_up_in &&
          state_q.count == 32'sd0);
        state_d.low_limit_flag = !count_up_in &&
          state_q.count == 32'sh8000_0000;
        state_d.high_limit_flag = count_up_in &&
          state_q.count == 32'sh7fff_ffff;
      end
    end
    if (sync_hit) begin
      state_d.sync_seen_flag = 1'b1;
    end
    state_d.status_clear_ack = nc.cmd[`CSPI_CB4_CLR_REQ];

    // Faults held until acknowledged with cause gone
    if (supply_short_in) begin
      state_d.encoder_supply_fault = 1'b1;
    end else if (ack) begin
      state_d.encoder_supply_fault = 1'b0;
    end
    do1 = nc.value[2:0];
    do2 = nc.value[5:4];
    if (do1 > 3'h4) begin
      state_d.param_fault = 1'b1;
    end else if (ack) begin
      state_d.param_fault = 1'b0;
    end

    // Pulse time base, 2 ms units
    tick = state_q.tick_cnt == 28'(PULSE_UNIT_CYC - 1);
    state_d.tick_cnt = tick ? 28'h0 : state_q.tick_cnt + 28'h1;

    reach1 = cnt == $signed(state_q.cmp1) && cnt != state_q.count;
    reach2 = cnt == $signed(state_q.cmp2) && cnt != state_q.count;
    if (do1 == 3'h3 && reach1) begin
      state_d.ptmr1 = nc.value[23:16];
    end else if (tick && state_q.ptmr1 != 8'h0) begin
      state_d.ptmr1 = state_q.ptmr1 - 8'h1;
    end
    if (do2 == 2'h3 && reach2) begin
      state_d.ptmr2 = nc.value[23:16];
    end else if (tick && state_q.ptmr2 != 8'h0) begin
      state_d.ptmr2 = state_q.ptmr2 - 8'h1;
    end

    case (do1)
      3'h1, 3'h2: state_d.out1 = cspi_level(do1[1:0], cnt,
        $signed(state_q.cmp1), nc.value[15:8], state_q.out1);
      3'h3: state_d.out1 = state_d.ptmr1 != 8'h0;
      3'h4: state_d.out1 = cnt >= $signed(state_q.cmp1) &&
                           cnt <= $signed(state_q.cmp2);
      default: state_d.out1 = 1'b0;
    endcase
    case (do2)
      2'h1, 2'h2: state_d.out2 = cspi_level(do2, cnt,
        $signed(state_q.cmp2), nc.value[15:8], state_q.out2);
      2'h3: state_d.out2 = state_d.ptmr2 != 8'h0;
      default: state_d.out2 = 1'b0;
    endcase

    // Feedback image, whole snapshot at the sample instant
    if (!iso_mode_in || sample_in) begin
      state_d.fb = '0;
      state_d.fb.count = (aux_func_in == CSPI_AUX_LATCH) ?
        state_q.latch_val : state_q.count;
      state_d.fb.count_ext = state_q.count;
      state_d.fb.fault[`CSPI_FB4_SUPPLY] =
        state_q.encoder_supply_fault;
      state_d.fb.fault[`CSPI_FB4_PARAM]    = state_q.param_fault;
      state_d.fb.fault[`CSPI_FB4_CLR_ACK]  = state_q.status_clear_ack;
      state_d.fb.fault[`CSPI_FB4_LOAD_FLT] = state_q.load_fault;
      state_d.fb.fault[`CSPI_FB4_LOAD_ACT] = state_q.load_active;
      state_d.fb.dirgate[`CSPI_FB5_DOWN]  = state_q.dir_down_flag;
      state_d.fb.dirgate[`CSPI_FB5_UP]    = state_q.dir_up_flag;
      state_d.fb.dirgate[`CSPI_FB5_LEVEL] = state_q.aux_s2;
      state_d.fb.dirgate[`CSPI_FB5_GATE]  = gate_int;
      state_d.fb.limsync[`CSPI_FB6_ZERO] = state_q.zero_cross_flag;
      state_d.fb.limsync[`CSPI_FB6_LOW]  = state_q.low_limit_flag;
      state_d.fb.limsync[`CSPI_FB6_HIGH] = state_q.high_limit_flag;
      state_d.fb.limsync[`CSPI_FB6_SYNC] =
        state_q.sync_seen_flag;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else if (ce_in) begin
      state_q <= state_d;
    end
  end

  assign fb_img_out     = state_q.fb;
  assign output_one_out = state_q.out1;
  assign output_two_out = state_q.out2;

endmodule : cspi_top

// ==== verification/cspi_top_props.sv ====
/*
  Checker of the counter slice ports: reserved image bits, level mirror,
  sample hold, sticky sync flag, clear ack, load fault and soft gate.
  Assumes binding onto cspi_top and ce_in held high by the bench.
*/
module cspi_top_props
  import cspi_pkg::*;
#(
  parameter int PULSE_UNIT_CYC = 4
) (
  input wire logic           clk_in,
  input wire logic           rstn_in,
  input wire logic           ce_in,
  input wire cspi_auxfn_t    aux_func_in,
  input wire logic           iso_mode_in,
  input wire logic           sample_in,
  input wire cspi_ctrl_img_t ctrl_img_in,
  input wire logic           ctrl_valid_in,
  input wire logic           aux_input_in,
  input wire cspi_fb_img_t   fb_img_out,
  input wire logic           output_one_out,
  input wire logic           output_two_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic gate_q;

  // Last soft gate bit taken, to spot its rising edge
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gate_q <= 1'b0;
    end else if (ctrl_valid_in && ce_in) begin
      gate_q <= ctrl_img_in.cmd[0];
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_reserved_zero: assert property (
    fb_img_out.spare == 8'h00 && fb_img_out.fault[6] == 1'b0
    && fb_img_out.fault[4:3] == 2'h0 && fb_img_out.dirgate[5:2] == 4'h0
    && fb_img_out.limsync[4:1] == 4'h0) else $error("reserved bit set");
  a_level_mirror: assert property (
    (!iso_mode_in && $stable(aux_input_in))[*8]
    |-> fb_img_out.dirgate[1] == aux_input_in)
    else $error("level flag off");
  a_iso_hold: assert property (iso_mode_in && !sample_in
    |=> $stable(fb_img_out)) else $error("image moved between samples");
  a_sync_sticky: assert property (
    (!iso_mode_in && !ctrl_valid_in)[*3] ##0 fb_img_out.limsync[0]
    |=> fb_img_out.limsync[0]) else $error("sync flag dropped");
  a_ack_follows: assert property (
    ctrl_valid_in && ce_in ##1 (ce_in && !iso_mode_in && !ctrl_valid_in)[*3]
    |-> fb_img_out.fault[2] == $past(ctrl_img_in.cmd[2], 3))
    else $error("clear ack differs from request");
  a_load_fault: assert property (
    ctrl_valid_in && ce_in && !iso_mode_in
    && !$onehot0(ctrl_img_in.load[3:0]) |-> ##[2:4] fb_img_out.fault[1])
    else $error("multi command not flagged");
  a_gate_opens: assert property (
    ctrl_valid_in && ce_in && ctrl_img_in.cmd[0] && !gate_q
    && aux_func_in != CSPI_AUX_HWGATE
    ##1 (!iso_mode_in && !ctrl_valid_in)[*3] |-> fb_img_out.dirgate[0])
    else $error("gate did not open");
  a_gate_closes: assert property (
    ctrl_valid_in && ce_in && !ctrl_img_in.cmd[0]
    ##1 (!iso_mode_in && !ctrl_valid_in)[*3] |-> !fb_img_out.dirgate[0])
    else $error("gate did not close");

  c_sync: cover property (fb_img_out.limsync[0]);
  c_outs: cover property (output_one_out && output_two_out);
  c_iso: cover property (iso_mode_in && sample_in);
endmodule : cspi_top_props

bind cspi_top cspi_top_props #(.PULSE_UNIT_CYC(PULSE_UNIT_CYC)) u_props (
  .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
  .aux_func_in(aux_func_in), .iso_mode_in(iso_mode_in),
  .sample_in(sample_in), .ctrl_img_in(ctrl_img_in),
  .ctrl_valid_in(ctrl_valid_in), .aux_input_in(aux_input_in),
  .fb_img_out(fb_img_out), .output_one_out(output_one_out),
  .output_two_out(output_two_out)
);

// ==== verification/cspi_bus_model.sv ====
/*
  Model of the fieldbus interface side: hands whole control images with
  a one-cycle valid and makes sample strobes in isochronous mode.
  Assumes the bench calls send and drives iso_en_in.
*/
module cspi_bus_model
  import cspi_pkg::*;
(
  input  wire logic      clk_in,
  input  wire logic      iso_en_in,
  output cspi_ctrl_img_t ctrl_img_out,
  output logic           ctrl_valid_out,
  output logic           sample_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] tick_q = 4'h0;

  initial begin
    ctrl_img_out   = '0;
    ctrl_valid_out = 1'b0;
    sample_out     = 1'b0;
  end

  always @(negedge clk_in) begin
    tick_q     <= tick_q + 4'h1;
    sample_out <= iso_en_in && (tick_q == 4'hf);
  end

  // Whole image in one strobe, then stale lines turned over
  task automatic send(input logic [31:0] v, input logic [7:0] c, l);
    @(negedge clk_in);
    ctrl_img_out   <= {v, c, l};
    ctrl_valid_out <= 1'b1;
    @(negedge clk_in);
    ctrl_valid_out <= 1'b0;
    ctrl_img_out   <= ~ctrl_img_out;
  endtask : send
endmodule : cspi_bus_model

// ==== verification/tb.sv ====
/*
  Testbench of the counter slice: sync once and periodic, status clear,
  faults, output compare modes, gate and isochronous sampling.
  Assumes cspi_top, the bus model and the bound checker are compiled.
*/
module tb;
  import cspi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic           clk = 1'b0;
  logic           rstn, periodic, iso, sample, valid;
  logic           aux, cpulse, cup, short_c, out1, out2;
  cspi_auxfn_t    func;
  cspi_ctrl_img_t img;
  cspi_fb_img_t   fb;
  logic [31:0]    seed, load_a, load_b;
  int             fail_count, check_count, n;

  always #4 clk = ~clk;

  cspi_top #(.PULSE_UNIT_CYC(4)) u_dut (
    .clk_in(clk), .rstn_in(rstn), .ce_in(1'b1), .aux_func_in(func),
    .sync_periodic_in(periodic), .iso_mode_in(iso), .sample_in(sample),
    .ctrl_img_in(img), .ctrl_valid_in(valid), .aux_input_in(aux),
    .count_pulse_in(cpulse), .count_up_in(cup), .supply_short_in(short_c),
    .fb_img_out(fb), .output_one_out(out1), .output_two_out(out2)
  );

  cspi_bus_model u_bus (
    .clk_in(clk), .iso_en_in(iso), .ctrl_img_out(img),
    .ctrl_valid_out(valid), .sample_out(sample)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic on_at(input int m, input int c, input int cmp);
    return (m == 1) ? (c >= cmp) : (m == 2) ? (c <= cmp) : 1'b0;
  endfunction : on_at

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk

  task automatic ref_edge();
    aux <= 1'b1;
    // Long enough for one sample strobe in isochronous mode
    cyc(20);
    chk(fb.dirgate[1] === 1'b1, "level flag low");
    aux <= 1'b0;
    cyc(8);
  endtask : ref_edge

  task automatic pulse_count(input int k, input logic up);
    repeat (k) begin
      cup    <= up;
      cpulse <= 1'b1;
      cyc(1);
      cpulse <= 1'b0;
      cyc(1);
    end
  endtask : pulse_count

  task automatic put(input logic [31:0] v, input logic [7:0] c, l);
    u_bus.send(v, c, l);
    cyc(6);
  endtask : put

  task automatic print_verdict();
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  initial begin
    cyc(3000);
    fail_count++;
    print_verdict();
  end

  initial begin
    {rstn, periodic, iso, aux, cpulse, cup, short_c} = '0;
    func = CSPI_AUX_SYNC;
    fail_count = 0;
    check_count = 0;
    seed = lfsr(32'h767f);
    load_a = seed;
    seed = lfsr(seed);
    load_b = seed;
    cyc(10);
    rstn = 1'b1;
    cyc(4);
    put(load_a, 8'h00, 8'h02);
    put(load_a, 8'h01, 8'h00);
    chk(fb.dirgate[0] === 1'b1, "gate not open");
    ref_edge();
    chk(fb.count === 32'h0 && !fb.limsync[0], "unarmed sync");
    put(load_a, 8'h03, 8'h00);
    ref_edge();
    chk(fb.count === load_a && fb.limsync[0], "once sync");
    put(load_b, 8'h03, 8'h02);
    ref_edge();
    chk(fb.count === load_a, "second edge reloaded");
    periodic = 1'b1;
    put(load_b, 8'h01, 8'h00);
    put(load_b, 8'h03, 8'h00);
    for (int i = 0; i < 2; i++) begin
      ref_edge();
      chk(fb.count === load_b, "periodic reload");
      n = int'(seed[2:0]) + 1;
      seed = lfsr(seed);
      pulse_count(n, 1'b1);
      cyc(4);
      chk(fb.count_ext === load_b + 32'(n), "count after sync");
    end
    put(load_b, 8'h07, 8'h00);
    chk(!fb.limsync[0] && fb.fault[2], "status clear");
    put(load_b, 8'h03, 8'h00);
    chk(fb.fault[2] === 1'b0, "clear ack stuck");
    put(load_b, 8'h03, 8'h03);
    chk(fb.fault[1] === 1'b1, "multi command");
    short_c <= 1'b1;
    put(load_b, 8'h83, 8'h00);
    chk(fb.fault[7] === 1'b1, "supply fault");
    put(load_b, 8'h03, 8'h00);
    short_c <= 1'b0;
    cyc(6);
    chk(fb.fault[7] === 1'b1, "fault left early");
    // Valid output code, so the param fault can clear as well
    put(32'h00, 8'h83, 8'h00);
    chk(fb.fault[7:0] === 8'h00, "fault ack");
    put(32'h11, 8'h03, 8'h04);
    put(32'h11, 8'h03, 8'h08);
    put(32'h11, 8'h03, 8'h01);
    pulse_count(1, 1'b0);
    for (int m = 1; m < 3; m++) begin
      put(32'(m * 17), 8'h03, 8'h00);
      for (int k = 16; k < 18; k++) begin
        chk(out1 === on_at(m, k, 17), "output one mode");
        chk(out2 === on_at(m, k, 17), "output two mode");
        pulse_count(1, 1'b1);
        cyc(4);
      end
      pulse_count(2, 1'b0);
    end
    put(32'h05, 8'h03, 8'h00);
    chk(fb.fault[5] === 1'b1, "blocked code");
    put(32'h00, 8'h03, 8'h00);
    chk(!out1 && !out2, "plain output");
    func = CSPI_AUX_LATCH;
    ref_edge();
    pulse_count(3, 1'b1);
    cyc(4);
    chk(fb.count === 32'h10 && fb.count_ext === 32'h13, "latch");
    chk(fb.dirgate[7:6] === 2'h1, "direction flags");
    func = CSPI_AUX_HWGATE;
    for (int h = 0; h < 2; h++) begin
      aux <= h[0];
      cyc(5);
      chk(fb.dirgate[0] === h[0], "hw gate");
    end
    aux <= 1'b0;
    func = CSPI_AUX_SYNC;
    put(32'h0002_0033, 8'h03, 8'h00);
    pulse_count(2, 1'b0);
    chk(out1 === 1'b1 && out2 === 1'b1, "pulse start");
    cyc(10);
    chk(out1 === 1'b0 && out2 === 1'b0, "pulse end");
    put(32'h04, 8'h03, 8'h00);
    chk(out1 === 1'b1 && out2 === 1'b0, "switch mode");
    pulse_count(1, 1'b1);
    chk(out1 === 1'b0, "switch mode off");
    put(32'h00, 8'h00, 8'h00);
    chk(fb.dirgate[0] === 1'b0, "gate closed");
    iso = 1'b1;
    put(32'h00, 8'h03, 8'h00);
    ref_edge();
    cyc(20);
    chk(fb.limsync[0] === 1'b1, "iso sync flag");
    print_verdict();
  end
endmodule : tb
